// file: rtl/cutoff_channel_filter.v
/*
 Low-pulse filter for one torque cutoff enable channel.
 Assumes the raw level is already synchronous to pclk and reads high
 only while the channel voltage is at the reliable enabled level.
*/
`default_nettype none

module cutoff_channel_filter #(
   parameter IGNORE_CYCLES = 250000
) (
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // Channel
   input  wire        raw_en,
   output reg         level_r
);

   reg  [31:0] low_cnt_r;

   // Low pulses up to the ignore time leave the level high
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt_r <= 32'h0000_0000;
         level_r   <= 1'b0;
      end else if (raw_en) begin
         low_cnt_r <= 32'h0000_0000;
         level_r   <= 1'b1;
      end else if (low_cnt_r < IGNORE_CYCLES) begin
         low_cnt_r <= low_cnt_r + 32'h0000_0001;
      end else begin
         level_r   <= 1'b0;
      end
   end

endmodule // cutoff_channel_filter

`default_nettype wire

// file: rtl/torque_cutoff_regs.vh
/*
 Constants of the torque cutoff supervisor: timing figures, register
 offsets, field positions, reset values and codes.
 Assumes it is included by bare name from the design files.
*/
`ifndef TORQUE_CUTOFF_REGS_VH
`define TORQUE_CUTOFF_REGS_VH

// Clock rate and times, each in its own unit
`define PCLK_MHZ          250
`define IGNORE_TIME_US    1000
`define INCONS_TIME_US    10000
`define DIAG_TIME_US      40000
`define SAFE_TIME_US      50000

// Commutation limit, 600 Hz, and seconds per minute
`define COMM_LIMIT_HZ     32'h0000_0258
`define SEC_PER_MIN       32'h0000_003C

// Register byte offsets
`define ADDR_CTRL         12'h000
`define ADDR_POLE         12'h004
`define ADDR_PERIOD       12'h008
`define ADDR_STATUS       12'h00C
`define ADDR_ERR_LOG      12'h010

// Control fields
`define CTRL_OPERATE      0
`define CTRL_RESET        1
`define CTRL_MTYPE_LO     2
`define CTRL_MTYPE_HI     3
`define CTRL_DC_CHECK     4

// Status fields
`define ST_STATE_LO       0
`define ST_STATE_HI       2
`define ST_ERR_LO         4
`define ST_ERR_HI         7
`define ST_DRV            8
`define ST_CHA            9
`define ST_CHB            10
`define ST_LIMITER        11

// Reset values
`define POLE_RST          8'h01
`define PERIOD_RST        16'h0001
`define MTYPE_RST         2'h0

// Motor types
`define MT_ROTARY         2'h0
`define MT_LINEAR         2'h1
`define MT_DC             2'h2

// Error codes, also bit positions of the error log
`define ERR_NONE          4'h0
`define ERR_CUTOFF        4'h1
`define ERR_MISMATCH      4'h2
`define ERR_STARTUP       4'h3
`define ERR_PULSE         4'h4
`define ERR_TEMP          4'h5
`define ERR_COMM          4'h6
`define ERR_OVERV         4'h7
`define ERR_UNDERV        4'h8

`endif

// file: rtl/torque_cutoff_supervisor.v
/*
 Torque cutoff supervisor: two-channel driver gating, warning and fault
 state machine, safe error states, supply supervision, commutation
 frequency limiter and an APB register slave.
 Assumes all inputs are synchronous to pclk, channel levels are already
 compared against the enable threshold, and presetn is the power cycle.
*/
// The register offsets and the APB register port were decided locally.
`default_nettype none
`include "torque_cutoff_regs.vh"

module torque_cutoff_supervisor #(
   parameter HIGH_SPEED    = 0,
   parameter IGNORE_CYCLES = `IGNORE_TIME_US * `PCLK_MHZ,
   parameter INCONS_CYCLES = `INCONS_TIME_US * `PCLK_MHZ,
   parameter DIAG_CYCLES   = `DIAG_TIME_US * `PCLK_MHZ
) (
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   // Cutoff channels
   input  wire        cutoff_channel_a_enable,
   input  wire        cutoff_channel_b_enable,
   // Diagnostic and supply monitors
   input  wire        diag_startup_ok,
   input  wire        pulse_test_fail,
   input  wire        diag_temp_fault,
   input  wire        drive_temp_warn,
   input  wire        bridge_volt_warn,
   input  wire        supply_over,
   input  wire        supply_under,
   // Motion feedback
   input  wire [23:0] comm_speed,
   // Outputs to the drive
   output reg         drv_enable,
   output reg         cutoff_active_condition,
   output reg         selftest_req,
   output reg         supply_off
);

   // States
   localparam [2:0] ST_DIAG    = 3'h0;
   localparam [2:0] ST_READY   = 3'h1;
   localparam [2:0] ST_OPER    = 3'h2;
   localparam [2:0] ST_NOTRDY  = 3'h3;
   localparam [2:0] ST_FAULT   = 3'h4;
   localparam [2:0] ST_SAFE    = 3'h5;
   localparam [2:0] ST_LOCK    = 3'h6;

   localparam [2:0] SEL_CTRL   = 3'h0;
   localparam [2:0] SEL_POLE   = 3'h1;
   localparam [2:0] SEL_PERIOD = 3'h2;
   localparam [2:0] SEL_STATUS = 3'h3;
   localparam [2:0] SEL_LOG    = 3'h4;
   localparam [2:0] SEL_NONE   = 3'h7;

   localparam LIMITER = (HIGH_SPEED == 0);

   // Register select, shared by write and read paths
   function [2:0] reg_sel;
      input [11:0] addr;
      begin
         case (addr)
            `ADDR_CTRL:    reg_sel = SEL_CTRL;
            `ADDR_POLE:    reg_sel = SEL_POLE;
            `ADDR_PERIOD:  reg_sel = SEL_PERIOD;
            `ADDR_STATUS:  reg_sel = SEL_STATUS;
            `ADDR_ERR_LOG: reg_sel = SEL_LOG;
            default:       reg_sel = SEL_NONE;
         endcase
      end
   endfunction

   reg  [2:0]  state_r;
   reg  [2:0]  state_nxt;
   reg  [3:0]  err_r;
   reg  [3:0]  err_nxt;
   reg  [31:0] diag_cnt_r;
   reg  [31:0] diag_cnt_nxt;
   reg         selftest_nxt;
   reg  [31:0] mm_cnt_r;
   reg         operate_r;
   reg         reset_cmd_r;
   reg  [1:0]  mtype_r;
   reg         dc_check_r;
   reg  [7:0]  pole_r;
   reg  [15:0] period_r;
   reg  [15:0] err_log_r;
   reg  [31:0] rdata;
   reg         comm_over;

   wire [1:0]  ch_level;
   wire [1:0]  ch_raw;
   wire        ch_a;
   wire        ch_b;
   wire        both_on;
   wire        both_off;
   wire        mismatch_exp;
   wire        warn_any;
   wire        access;
   wire        wr_en;
   wire [2:0]  sel;
   wire [31:0] rot_prod;
   wire [31:0] rot_lim;
   wire [31:0] lin_lim;
   wire [8:1]  log_set;
   wire [15:0] log_clr;

   assign ch_raw = {cutoff_channel_b_enable, cutoff_channel_a_enable};

   // One filter per channel
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
         cutoff_channel_filter #(
            .IGNORE_CYCLES (IGNORE_CYCLES)
         ) u_filter (
            .pclk    (pclk),
            .presetn (presetn),
            .raw_en  (ch_raw[gi]),
            .level_r (ch_level[gi])
         );
      end
   endgenerate

   assign ch_a     = ch_level[0];
   assign ch_b     = ch_level[1];
   assign both_on  = ch_a & ch_b;
   assign both_off = ~ch_a & ~ch_b;
   assign warn_any = both_off | drive_temp_warn | bridge_volt_warn;

   // Mismatch timer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mm_cnt_r <= 32'h0000_0000;
      end else if (ch_a != ch_b) begin
         if (mm_cnt_r < INCONS_CYCLES) begin
            mm_cnt_r <= mm_cnt_r + 32'h0000_0001;
         end
      end else begin
         mm_cnt_r <= 32'h0000_0000;
      end
   end

   assign mismatch_exp = (mm_cnt_r == INCONS_CYCLES);

   // Commutation frequency check
   assign rot_prod = {8'h00, comm_speed} * {24'h00_0000, pole_r};
   assign rot_lim  = `COMM_LIMIT_HZ * `SEC_PER_MIN;
   assign lin_lim  = {16'h0000, period_r} * `COMM_LIMIT_HZ;

   always @* begin
      comm_over = 1'b0;
      if (LIMITER) begin
         case (mtype_r)
            `MT_ROTARY: comm_over = rot_prod > rot_lim;
            `MT_LINEAR: comm_over =
               {8'h00, comm_speed} > lin_lim;
            `MT_DC:     comm_over =
               dc_check_r & (rot_prod > rot_lim);
            default:    comm_over = 1'b0;
         endcase
      end
   end

   // Supervisor state machine
   always @* begin
      state_nxt    = state_r;
      err_nxt      = err_r;
      diag_cnt_nxt = 32'h0000_0000;
      selftest_nxt = (state_r == ST_DIAG) &&
                     (diag_cnt_r == 32'h0000_0000);
      if (supply_over) begin
         state_nxt = ST_LOCK;
         err_nxt   = `ERR_OVERV;
      end else if (state_r == ST_LOCK) begin
         state_nxt = ST_LOCK;
      end else if (state_r == ST_SAFE) begin
         if (reset_cmd_r) begin
            state_nxt = ST_DIAG;
         end
      end else if (supply_under) begin
         state_nxt = ST_SAFE;
         err_nxt   = `ERR_UNDERV;
      end else if (mismatch_exp) begin
         state_nxt = ST_SAFE;
         err_nxt   = `ERR_MISMATCH;
      end else if (pulse_test_fail) begin
         state_nxt = ST_SAFE;
         err_nxt   = `ERR_PULSE;
      end else if (diag_temp_fault) begin
         state_nxt = ST_SAFE;
         err_nxt   = `ERR_TEMP;
      end else begin
         case (state_r)
            ST_DIAG: begin
               diag_cnt_nxt = diag_cnt_r + 32'h0000_0001;
               if (diag_cnt_r == DIAG_CYCLES - 1) begin
                  diag_cnt_nxt = 32'h0000_0000;
                  if (!diag_startup_ok) begin
                     state_nxt = ST_SAFE;
                     err_nxt   = `ERR_STARTUP;
                  end else if (warn_any) begin
                     state_nxt = ST_NOTRDY;
                     err_nxt   = both_off ? `ERR_CUTOFF : `ERR_NONE;
                  end else begin
                     state_nxt = ST_READY;
                     err_nxt   = `ERR_NONE;
                  end
               end
            end
            ST_READY: begin
               if (warn_any) begin
                  state_nxt = ST_NOTRDY;
                  err_nxt   = both_off ? `ERR_CUTOFF : `ERR_NONE;
               end else if (operate_r && both_on) begin
                  state_nxt = ST_OPER;
               end
            end
            ST_NOTRDY: begin
               err_nxt = both_off ? `ERR_CUTOFF : `ERR_NONE;
               if (!warn_any) begin
                  state_nxt = ST_READY;
               end
            end
            ST_OPER: begin
               if (both_off) begin
                  state_nxt = ST_FAULT;
                  err_nxt   = `ERR_CUTOFF;
               end else if (comm_over) begin
                  state_nxt = ST_FAULT;
                  err_nxt   = `ERR_COMM;
               end else if (!operate_r) begin
                  state_nxt = ST_READY;
               end
            end
            ST_FAULT: begin
               if (reset_cmd_r) begin
                  selftest_nxt = (err_r == `ERR_CUTOFF);
                  state_nxt = warn_any ? ST_NOTRDY : ST_READY;
                  err_nxt   = both_off ? `ERR_CUTOFF : `ERR_NONE;
               end
            end
            default: begin
               state_nxt = ST_SAFE;
               err_nxt   = `ERR_STARTUP;
            end
         endcase
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r                 <= ST_DIAG;
         err_r                   <= `ERR_NONE;
         diag_cnt_r              <= 32'h0000_0000;
         selftest_req            <= 1'b0;
         drv_enable              <= 1'b0;
         cutoff_active_condition <= 1'b1;
         supply_off              <= 1'b0;
      end else begin
         state_r                 <= state_nxt;
         err_r                   <= err_nxt;
         diag_cnt_r              <= diag_cnt_nxt;
         selftest_req            <= selftest_nxt;
         drv_enable              <= (state_nxt == ST_OPER) &
                                    both_on;
         cutoff_active_condition <= ~both_on;
         supply_off              <= (state_nxt == ST_LOCK);
      end
   end

   // APB slave, zero wait states
   assign access  = psel & penable;
   assign sel     = reg_sel(paddr);
   assign wr_en   = access & pwrite & (sel != SEL_NONE);
   assign pready  = 1'b1;
   assign pslverr = access & (sel == SEL_NONE);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         operate_r   <= 1'b0;
         reset_cmd_r <= 1'b0;
         mtype_r     <= `MTYPE_RST;
         dc_check_r  <= 1'b0;
         pole_r      <= `POLE_RST;
         period_r    <= `PERIOD_RST;
      end else begin
         reset_cmd_r <= wr_en & (sel == SEL_CTRL) &
                        pwdata[`CTRL_RESET];
         if (wr_en && sel == SEL_CTRL) begin
            operate_r  <= pwdata[`CTRL_OPERATE];
            mtype_r    <= pwdata[`CTRL_MTYPE_HI:`CTRL_MTYPE_LO];
            dc_check_r <= pwdata[`CTRL_DC_CHECK];
         end
         // Leaving operation drops the run request so nothing restarts
         if (state_nxt == ST_FAULT || state_nxt == ST_SAFE ||
             state_nxt == ST_LOCK) begin
            operate_r <= 1'b0;
         end
         if (wr_en && sel == SEL_POLE) begin
            pole_r <= pwdata[7:0];
         end
         if (wr_en && sel == SEL_PERIOD) begin
            period_r <= pwdata[15:0];
         end
      end
   end

   // Error log: sticky per cause, write one clears, a new cause wins
   genvar gl;
   generate
      for (gl = 1; gl < 9; gl = gl + 1) begin : g_log
         assign log_set[gl] = (err_nxt == gl) && (err_r != gl);
      end
   endgenerate

   assign log_clr = (wr_en && sel == SEL_LOG) ? pwdata[15:0] : 16'h0000;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_log_r <= 16'h0000;
      end else begin
         err_log_r <= (err_log_r & ~log_clr) | {7'h00, log_set, 1'b0};
      end
   end

   // Read mux
   always @* begin
      rdata = 32'h0000_0000;
      case (sel)
         SEL_CTRL: begin
            rdata[`CTRL_OPERATE]               = operate_r;
            rdata[`CTRL_MTYPE_HI:`CTRL_MTYPE_LO] = mtype_r;
            rdata[`CTRL_DC_CHECK]              = dc_check_r;
         end
         SEL_POLE:   rdata[7:0]  = pole_r;
         SEL_PERIOD: rdata[15:0] = period_r;
         SEL_STATUS: begin
            rdata[`ST_STATE_HI:`ST_STATE_LO] = state_r;
            rdata[`ST_ERR_HI:`ST_ERR_LO]     = err_r;
            rdata[`ST_DRV]                   = drv_enable;
            rdata[`ST_CHA]                   = ch_a;
            rdata[`ST_CHB]                   = ch_b;
            rdata[`ST_LIMITER]               = LIMITER;
         end
         SEL_LOG:    rdata[15:0] = err_log_r;
         default:    rdata = 32'h0000_0000;
      endcase
   end

   // Read data captured in the setup phase, valid through the access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rdata;
      end
   end

endmodule // torque_cutoff_supervisor

`default_nettype wire

// file: verif/cutoff_switch.sv
/*
 Model of the external safety switch driving both cutoff channels.
 Assumes the bench commands the levels and the diagnostic pulses.
*/
`default_nettype none
module cutoff_switch #(
   parameter int PULSE_LEN = 8
) (
   // Clock
   input  wire logic pclk,
   // Commands
   input  wire logic a_req,
   input  wire logic b_req,
   input  wire logic pulse_go,
   // Channels
   output logic      ch_a,
   output logic      ch_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] pulse_cnt_r = 8'h00;
   // Diagnostic low pulse, never longer than the ignore time
   always @(posedge pclk) begin
      if (pulse_go)
         pulse_cnt_r <= 8'(PULSE_LEN);
      else if (pulse_cnt_r != 8'h00)
         pulse_cnt_r <= pulse_cnt_r - 8'h01;
   end
   assign ch_a = a_req && (pulse_cnt_r == 8'h00);
   assign ch_b = b_req;
endmodule // cutoff_switch
`default_nettype wire

// file: verif/torque_cutoff_properties.sv
/*
 Checker for the torque cutoff supervisor, bound to its top module.
 Assumes channel and monitor inputs are synchronous to pclk.
*/
`default_nettype none
module torque_cutoff_properties #(
   parameter int IGNORE_CYCLES = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Channels and monitors
   input wire logic cutoff_channel_a_enable,
   input wire logic cutoff_channel_b_enable,
   input wire logic pulse_test_fail,
   input wire logic diag_temp_fault,
   input wire logic supply_over,
   input wire logic supply_under,
   // Outputs to the drive
   input wire logic drv_enable,
   input wire logic cutoff_active_condition,
   input wire logic selftest_req,
   input wire logic supply_off
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LATE = IGNORE_CYCLES + 2;
   logic [31:0] low_a_r;
   logic [31:0] low_b_r;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Length of the current low run on each channel
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_a_r <= 32'h0;
         low_b_r <= 32'h0;
      end else begin
         low_a_r <= cutoff_channel_a_enable ? 32'h0 : low_a_r + 32'h1;
         low_b_r <= cutoff_channel_b_enable ? 32'h0 : low_b_r + 32'h1;
      end
   end
   sequence s_safe;
      !drv_enable && supply_off;
   endsequence
   sequence s_pulse;
      selftest_req ##1 !selftest_req;
   endsequence
   AST_DRV_LATE: assert property ((low_a_r > LATE || low_b_r > LATE)
      |-> !drv_enable && cutoff_active_condition)
      else $error("drivers on after a long channel low");
   AST_DRV_ROSE: assert property ($rose(drv_enable)
      |-> cutoff_channel_a_enable && cutoff_channel_b_enable)
      else $error("drivers enabled with a channel low");
   AST_DRV_COND: assert property (drv_enable
      |-> !cutoff_active_condition)
      else $error("drivers on while cutoff is active");
   AST_OVERV: assert property (supply_over |-> ##[1:3] s_safe)
      else $error("overvoltage did not lock the supply off");
   AST_LOCK_HOLD: assert property (supply_off |=> supply_off)
      else $error("supply lock released without power cycle");
   AST_UNDERV: assert property (supply_under |-> ##[1:3] !drv_enable)
      else $error("undervoltage left the drivers on");
   AST_PULSE_FAIL: assert property (pulse_test_fail
      |-> ##[1:3] !drv_enable)
      else $error("pulse test failure left the drivers on");
   AST_TEMP: assert property (diag_temp_fault |-> ##[1:3] !drv_enable)
      else $error("temperature fault left the drivers on");
   AST_SELFTEST_ONE: assert property (selftest_req |-> s_pulse)
      else $error("self test request longer than one cycle");
   AST_SELFTEST_OFF: assert property (selftest_req |-> !drv_enable)
      else $error("self test requested during operation");
endmodule // torque_cutoff_properties

bind torque_cutoff_supervisor torque_cutoff_properties #(
   .IGNORE_CYCLES(IGNORE_CYCLES)
) i_torque_cutoff_properties (
   .pclk(pclk), .presetn(presetn),
   .cutoff_channel_a_enable(cutoff_channel_a_enable),
   .cutoff_channel_b_enable(cutoff_channel_b_enable),
   .pulse_test_fail(pulse_test_fail), .diag_temp_fault(diag_temp_fault),
   .supply_over(supply_over), .supply_under(supply_under),
   .drv_enable(drv_enable), .selftest_req(selftest_req),
   .cutoff_active_condition(cutoff_active_condition),
   .supply_off(supply_off)
);
`default_nettype wire

// file: verif/torque_cutoff_supervisor_tb.sv
/*
 Self-checking bench of the torque cutoff supervisor over APB.
 Assumes the design, the switch model and the checker are compiled.
*/
`default_nettype none
module torque_cutoff_supervisor_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int IGN = 8;
   localparam int DIAG = 30;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic        a_req, b_req, pulse_go, ch_a, ch_b, ok, twarn, bwarn;
   logic        over, drv_enable, cut, selftest_req, supply_off;
   logic [2:0]  flt;
   logic [23:0] speed;
   int          fails, comparisons, nst, i;
   logic [31:0] tctl [6];
   logic [23:0] tspd [6];
   logic [3:0]  ecode [4];

   torque_cutoff_supervisor #(.IGNORE_CYCLES(IGN), .INCONS_CYCLES(20),
      .DIAG_CYCLES(DIAG)) i_torque_cutoff_supervisor (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cutoff_channel_a_enable(ch_a),
      .cutoff_channel_b_enable(ch_b), .diag_startup_ok(ok),
      .pulse_test_fail(flt[0]), .diag_temp_fault(flt[1]),
      .drive_temp_warn(twarn), .bridge_volt_warn(bwarn),
      .supply_over(over), .supply_under(flt[2]), .comm_speed(speed),
      .drv_enable(drv_enable), .cutoff_active_condition(cut),
      .selftest_req(selftest_req), .supply_off(supply_off));

   cutoff_switch i_cutoff_switch (.pclk(pclk), .a_req(a_req),
      .b_req(b_req), .pulse_go(pulse_go), .ch_a(ch_a), .ch_b(ch_b));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   always @(posedge pclk) if (selftest_req === 1'b1) nst <= nst + 1;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic run(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Compares state and error code of the status word
   task automatic st(input logic [2:0] s, input logic [3:0] c);
      xfer(1'b0, 12'h00C, 32'h0);
      chk(32'(q[7:0]), {24'h0, c, 1'b0, s});
   endtask

   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      run(20000);
      fails++;
      final_report();
   end

   initial begin
      {presetn, psel, penable, pwrite, pulse_go, twarn, bwarn, over} = 8'h0;
      {paddr, pwdata, speed, flt} = 71'h0;
      {a_req, b_req, ok} = 3'h7;
      {fails, comparisons, nst} = 96'h0;
      tctl = '{32'h1, 32'h1, 32'h5, 32'h5, 32'h9, 32'h19};
      tspd = '{24'd18000, 24'd18001, 24'd6000, 24'd6001, 24'hFFFFFF,
               24'hFFFFFF};
      ecode = '{4'h4, 4'h5, 4'h8, 4'h4};
      run(10);
      presetn <= 1'b1;
      st(3'h0, 4'h0);
      xfer(1'b0, 12'h004, 32'h0);
      chk(q, 32'h1);
      xfer(1'b0, 12'h008, 32'h0);
      chk(q, 32'h1);
      xfer(1'b0, 12'h014, 32'h0);
      chk({q[30:0], e}, 32'h1);
      run(DIAG + 10);
      st(3'h1, 4'h0);
      chk(32'(q[11]), 32'h1);
      xfer(1'b1, 12'h000, 32'h1);
      run(5);
      st(3'h2, 4'h0);
      pulse_go <= 1'b1;
      run(1);
      pulse_go <= 1'b0;
      run(20);
      chk(32'(drv_enable), 32'h1);
      chk(32'(cut), 32'h0);
      {a_req, b_req} <= 2'h0;
      run(IGN + 6);
      st(3'h4, 4'h1);
      chk(32'(cut), 32'h1);
      xfer(1'b1, 12'h000, 32'h1);
      chk(32'(drv_enable), 32'h0);
      chk(nst, 32'h1);
      xfer(1'b1, 12'h000, 32'h2);
      run(3);
      st(3'h3, 4'h1);
      chk(nst, 32'h2);
      {a_req, b_req} <= 2'h3;
      run(5);
      st(3'h1, 4'h0);
      {a_req, b_req} <= 2'h0;
      run(IGN + 6);
      st(3'h3, 4'h1);
      {a_req, b_req} <= 2'h3;
      run(5);
      st(3'h1, 4'h0);
      for (i = 0; i < 3; i++) begin
         a_req <= 1'b0;
         run(i == 2 ? 40 : 22);
         a_req <= 1'b1;
         run(5);
         st(i == 2 ? 3'h5 : 3'h1, i == 2 ? 4'h2 : 4'h0);
      end
      xfer(1'b1, 12'h000, 32'h2);
      run(DIAG + 10);
      st(3'h1, 4'h0);
      for (i = 0; i < 4; i++) begin
         flt <= 3'(1 << (i % 3));
         run(3);
         st(3'h5, ecode[i]);
         flt <= 3'h0;
         ok <= (i != 3);
         xfer(1'b1, 12'h000, 32'h2);
         run(DIAG + 10);
         st(i == 3 ? 3'h5 : 3'h1, i == 3 ? 4'h3 : 4'h0);
      end
      ok <= 1'b1;
      xfer(1'b1, 12'h000, 32'h2);
      run(DIAG + 10);
      st(3'h1, 4'h0);
      xfer(1'b1, 12'h004, 32'h2);
      xfer(1'b1, 12'h008, 32'hA);
      for (i = 0; i < 6; i++) begin
         speed <= tspd[i];
         xfer(1'b1, 12'h000, tctl[i]);
         run(5);
         st(i % 2 ? 3'h4 : 3'h2, i % 2 ? 4'h6 : 4'h0);
         speed <= 24'h0;
         xfer(1'b1, 12'h000, 32'h0);
         xfer(1'b1, 12'h000, 32'h2);
         run(3);
      end
      // Fault reset with a drive warning still standing
      speed <= 24'hFFFFFF;
      xfer(1'b1, 12'h000, 32'h1);
      run(5);
      twarn <= 1'b1;
      xfer(1'b1, 12'h000, 32'h2);
      run(3);
      st(3'h3, 4'h0);
      twarn <= 1'b0;
      bwarn <= 1'b1;
      speed <= 24'h0;
      run(3);
      st(3'h3, 4'h0);
      bwarn <= 1'b0;
      run(3);
      st(3'h1, 4'h0);
      xfer(1'b0, 12'h010, 32'h0);
      chk(q, 32'h0000_017E);
      xfer(1'b1, 12'h010, 32'h0000_01FE);
      over <= 1'b1;
      run(3);
      st(3'h6, 4'h7);
      over <= 1'b0;
      xfer(1'b1, 12'h000, 32'h2);
      run(DIAG + 10);
      st(3'h6, 4'h7);
      chk(32'(supply_off), 32'h1);
      xfer(1'b0, 12'h010, 32'h0);
      chk(q, 32'h0000_0080);
      final_report();
   end
endmodule // torque_cutoff_supervisor_tb
`default_nettype wire
